/* File: hdl/gpb_pkg.sv */
// Constants, register map and helpers for the three-port GPIO block.
// Assumes an 8-bit CPU special-function-register access port on clk_sys_i.
package gpb_pkg;
	// ********************************
	// Geometry
	// ********************************
	localparam int GPB_W = 8;
	localparam int GPB_NPORTS = 3;
	localparam logic [GPB_NPORTS-1:0] GPB_HAS_PU = 3'h5;
	// ********************************
	// Register map
	// ********************************
	localparam logic [15:0] GPB_DIR_ADDR [GPB_NPORTS] = '{16'hff20, 16'hff22, 16'hff24};
	localparam logic [15:0] GPB_PUB_ADDR [GPB_NPORTS] = '{16'hff30, 16'hff32, 16'hff34};
	localparam logic [15:0] GPB_LAT_ADDR [GPB_NPORTS] = '{16'hff00, 16'hff02, 16'hff04};
	// ********************************
	// Reset values
	// ********************************
	localparam logic [GPB_W-1:0] GPB_DIR_RST = 8'hff;
	localparam logic [GPB_W-1:0] GPB_PUB_RST = 8'h00;
	localparam logic [GPB_W-1:0] GPB_LAT_RST = 8'h00;
	localparam logic [GPB_W-1:0] GPB_RD_NONE = 8'h00;
	// ********************************
	// Alternate function pins
	// ********************************
	localparam int GPB_TMR_PORT = 1;
	localparam int GPB_TMR_BIT = 3;
	localparam int GPB_CPT_BIT = 4;
	localparam int GPB_KEY_PORT = 2;
	localparam int GPB_INT0_BIT = 6;
	localparam int GPB_INT1_BIT = 7;

	// Replaces one bit of a byte
	function automatic logic [GPB_W-1:0] gpb_merge_bit(input logic [GPB_W-1:0] old,
		input logic [2:0] sel, input logic val);
		logic [GPB_W-1:0] res;
		res = old;
		res[sel] = val;
		return res;
	endfunction
endpackage

/* File: hdl/gpb_port_if.sv */
// Signals between the register decoder and one 8-bit port.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface gpb_port_if #(parameter int W = 8);
	logic wr_dir;
	logic wr_lat;
	logic wr_pub;
	logic [W-1:0] wdata;
	logic [W-1:0] dir;
	logic [W-1:0] lat;
	logic [W-1:0] pub;
	logic [W-1:0] level;
	logic [W-1:0] rdval;
	modport ctrl(output wr_dir, output wr_lat, output wr_pub, output wdata,
		input dir, input lat, input pub, input level, input rdval);
	modport port(input wr_dir, input wr_lat, input wr_pub, input wdata,
		output dir, output lat, output pub, output level, output rdval);
endinterface

/* File: hdl/gpb_sync.sv */
// Two-stage synchroniser for pin levels.
// Assumes asynchronous inputs and a synchronous active-high reset.
`timescale 1ns/1ns
module gpb_sync #(
	parameter int W = 8
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gpb_sync_state_t;

	gpb_sync_state_t st;
	gpb_sync_state_t next_st;

	always_comb begin
		next_st.s1 = d_i;
		next_st.s2 = st.s1;
		if (srst_i) begin
			next_st = '0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		st <= next_st;
	end

	assign q_o = st.s2;
endmodule

/* File: hdl/gpb_port.sv */
// One 8-bit port: direction, output latch, pull-up select, pin sampling.
// Assumes write strobes are one-hot per access, from the decoder.
`timescale 1ns/1ns
module gpb_port
	import gpb_pkg::*;
#(
	parameter bit HAS_PU = 1'b1
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [GPB_W-1:0] pin_i,
	gpb_port_if.port pif
);
	typedef struct packed {
		logic [GPB_W-1:0] dir;
		logic [GPB_W-1:0] lat;
		logic [GPB_W-1:0] pub;
	} gpb_port_state_t;

	gpb_port_state_t st;
	gpb_port_state_t next_st;

	gpb_sync #(.W(GPB_W)) u_sync (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.d_i(pin_i),
		.q_o(pif.level)
	);

	always_comb begin
		next_st = st;
		if (pif.wr_dir) begin
			next_st.dir = pif.wdata;
		end
		if (pif.wr_lat) begin
			next_st.lat = pif.wdata;
		end
		if (pif.wr_pub && HAS_PU) begin
			next_st.pub = pif.wdata;
		end
		if (srst_i) begin
			next_st.dir = GPB_DIR_RST;
			next_st.lat = GPB_LAT_RST;
			next_st.pub = GPB_PUB_RST;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		st <= next_st;
	end

	assign pif.dir = st.dir;
	assign pif.lat = st.lat;
	assign pif.pub = st.pub;
	// Output-mode bits read the latch, input-mode bits read the pin
	assign pif.rdval = (st.dir & pif.level) | (~st.dir & st.lat);
endmodule

/* File: hdl/gpb_top.sv */
// Three-port GPIO block with direction, latch and pull-up registers.
// Assumes a CPU register port: one-cycle strobes, address stable with them.
`timescale 1ns/1ns

module gpb_top
	import gpb_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [15:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [GPB_W-1:0] sfr_wdata_i,
	input wire logic sfr_bit_wr_i,
	input wire logic [2:0] sfr_bit_sel_i,
	input wire logic sfr_bit_val_i,
	input wire logic sfr_rd_i,
	output logic [GPB_W-1:0] sfr_rdata_o,
	input wire logic [GPB_NPORTS*GPB_W-1:0] pin_i,
	output logic [GPB_NPORTS*GPB_W-1:0] pin_o,
	output logic [GPB_NPORTS*GPB_W-1:0] pin_oe_n_o,
	output logic [2*GPB_W-1:0] pullup_en_o,
	input wire logic timer_output_pin_i,
	output logic capture_trigger_input_o,
	output logic [5:0] key_return_inputs_low_o,
	output logic key_return_input_6_o,
	output logic key_return_input_7_o,
	output logic ext_interrupt_input_0_o,
	output logic ext_interrupt_input_1_o
);
	typedef struct packed {
		logic [GPB_W-1:0] rdata;
	} gpb_top_state_t;

	gpb_top_state_t st;
	gpb_top_state_t next_st;

	logic wr_any;
	logic [GPB_W-1:0] port_rd [GPB_NPORTS];
	logic [GPB_W-1:0] rd_val;

	gpb_port_if #(.W(GPB_W)) pif [GPB_NPORTS] ();

	assign wr_any = sfr_wr_i | sfr_bit_wr_i;

	// ********************************
	// Per-port decode and pins
	// ********************************
	genvar k;
	generate
		for (k = 0; k < GPB_NPORTS; k++) begin : g_port
			logic hit_dir;
			logic hit_lat;
			logic hit_pub;
			logic [GPB_W-1:0] drive;

			assign hit_dir = (sfr_addr_i == GPB_DIR_ADDR[k]);
			assign hit_lat = (sfr_addr_i == GPB_LAT_ADDR[k]);
			assign hit_pub = (sfr_addr_i == GPB_PUB_ADDR[k]) && GPB_HAS_PU[k];

			assign pif[k].wr_dir = wr_any & hit_dir;
			assign pif[k].wr_lat = wr_any & hit_lat;
			assign pif[k].wr_pub = wr_any & hit_pub;

			// Bit writes rebuild the whole byte from its current read value
			always_comb begin
				pif[k].wdata = sfr_wdata_i;
				if (sfr_bit_wr_i) begin
					if (hit_dir) begin
						pif[k].wdata = gpb_merge_bit(pif[k].dir, sfr_bit_sel_i,
							sfr_bit_val_i);
					end else if (hit_pub) begin
						pif[k].wdata = gpb_merge_bit(pif[k].pub, sfr_bit_sel_i,
							sfr_bit_val_i);
					end else begin
						pif[k].wdata = gpb_merge_bit(pif[k].rdval, sfr_bit_sel_i,
							sfr_bit_val_i);
					end
				end
			end

			always_comb begin
				port_rd[k] = GPB_RD_NONE;
				if (hit_dir) begin
					port_rd[k] = pif[k].dir;
				end else if (hit_pub) begin
					port_rd[k] = pif[k].pub;
				end else if (hit_lat) begin
					port_rd[k] = pif[k].rdval;
				end
			end

			// Timer output is ORed in, so it needs a cleared latch
			always_comb begin
				drive = pif[k].lat;
				if (k == GPB_TMR_PORT) begin
					drive[GPB_TMR_BIT] = pif[k].lat[GPB_TMR_BIT] | timer_output_pin_i;
				end
			end

			assign pin_o[k*GPB_W +: GPB_W] = drive;
			assign pin_oe_n_o[k*GPB_W +: GPB_W] = pif[k].dir;

			gpb_port #(.HAS_PU(GPB_HAS_PU[k])) u_port (
				.clk_sys_i(clk_sys_i),
				.srst_i(srst_i),
				.pin_i(pin_i[k*GPB_W +: GPB_W]),
				.pif(pif[k])
			);
		end
	endgenerate

	// ********************************
	// Pull-ups and alternate inputs
	// ********************************
	assign pullup_en_o[GPB_W-1:0] = pif[0].pub & pif[0].dir;
	assign pullup_en_o[2*GPB_W-1:GPB_W] = pif[2].pub & pif[2].dir;

	assign capture_trigger_input_o = pif[GPB_TMR_PORT].level[GPB_CPT_BIT];
	assign key_return_inputs_low_o = pif[GPB_KEY_PORT].level[5:0];
	assign key_return_input_6_o = pif[GPB_KEY_PORT].level[GPB_INT0_BIT];
	assign key_return_input_7_o = pif[GPB_KEY_PORT].level[GPB_INT1_BIT];
	// Pin levels, not latches, so driven changes also raise requests
	assign ext_interrupt_input_0_o = pif[GPB_KEY_PORT].level[GPB_INT0_BIT];
	assign ext_interrupt_input_1_o = pif[GPB_KEY_PORT].level[GPB_INT1_BIT];

	// ********************************
	// Read data register
	// ********************************
	always_comb begin
		rd_val = GPB_RD_NONE;
		for (int i = 0; i < GPB_NPORTS; i++) begin
			rd_val = rd_val | port_rd[i];
		end
	end

	always_comb begin
		next_st = st;
		if (sfr_rd_i) begin
			next_st.rdata = rd_val;
		end
		if (srst_i) begin
			next_st.rdata = GPB_RD_NONE;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		st <= next_st;
	end

	assign sfr_rdata_o = st.rdata;

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);

	generate
		for (k = 0; k < GPB_NPORTS; k++) begin : g_chk
			property p_rst_dir;
				$past(srst_i) |-> pif[k].dir == GPB_DIR_RST
					&& pin_oe_n_o[k*GPB_W +: GPB_W] == GPB_DIR_RST;
			endproperty
			a_rst_dir: assert property (p_rst_dir) else $error("dir not input after reset");

			property p_rst_pub;
				$past(srst_i) |-> pif[k].pub == GPB_PUB_RST;
			endproperty
			a_rst_pub: assert property (p_rst_pub) else $error("pull-up not cleared");

			property p_byte_dir;
				sfr_wr_i && !sfr_bit_wr_i && g_port[k].hit_dir
					|=> pin_oe_n_o[k*GPB_W +: GPB_W] == $past(sfr_wdata_i);
			endproperty
			a_byte_dir: assert property (p_byte_dir) else $error("byte dir write lost");

			property p_bit_dir;
				sfr_bit_wr_i && g_port[k].hit_dir |=> pif[k].dir ==
					gpb_merge_bit($past(pif[k].dir), $past(sfr_bit_sel_i), $past(sfr_bit_val_i));
			endproperty
			a_bit_dir: assert property (p_bit_dir) else $error("bit dir write wrong");

			property p_lat_hold;
				!pif[k].wr_lat |=> pin_o[k*GPB_W +: GPB_W] == $past(pin_o[k*GPB_W +: GPB_W])
					|| k == GPB_TMR_PORT;
			endproperty
			a_lat_hold: assert property (p_lat_hold) else $error("latch changed unwritten");

			property p_in_write;
				sfr_wr_i && g_port[k].hit_lat && pif[k].dir == GPB_DIR_RST
					|=> pin_oe_n_o[k*GPB_W +: GPB_W] == GPB_DIR_RST
					&& pif[k].lat == $past(sfr_wdata_i);
			endproperty
			a_in_write: assert property (p_in_write) else $error("input-mode write wrong");

			property p_rd_out;
				sfr_rd_i && g_port[k].hit_lat && pif[k].dir == '0 |=> sfr_rdata_o == $past(pif[k].lat);
			endproperty
			a_rd_out: assert property (p_rd_out) else $error("output-mode read wrong");

			property p_rd_in;
				sfr_rd_i && g_port[k].hit_lat && pif[k].dir == GPB_DIR_RST
					|=> sfr_rdata_o == $past(pif[k].level) ##1 pif[k].lat == $past(pif[k].lat, 2);
			endproperty
			a_rd_in: assert property (p_rd_in) else $error("input-mode read wrong");

			property p_rmw_out;
				sfr_bit_wr_i && !sfr_wr_i && g_port[k].hit_lat && pif[k].dir == '0
					|=> pif[k].lat == gpb_merge_bit($past(pif[k].lat), $past(sfr_bit_sel_i),
					$past(sfr_bit_val_i));
			endproperty
			a_rmw_out: assert property (p_rmw_out) else $error("output-mode bit write wrong");

			property p_pu_out;
				(pullup_en_o & ~{pin_oe_n_o[3*GPB_W-1:2*GPB_W], pin_oe_n_o[GPB_W-1:0]}) == '0 || k != 0;
			endproperty
			a_pu_out: assert property (p_pu_out) else $error("pull-up on output pin");

			property p_lat_write;
				sfr_wr_i && !sfr_bit_wr_i && g_port[k].hit_lat |=> pif[k].lat == $past(sfr_wdata_i);
			endproperty
			a_lat_write: assert property (p_lat_write) else $error("latch byte write lost");

			property p_lat_rst;
				$past(srst_i) |-> pif[k].lat == GPB_LAT_RST;
			endproperty
			a_lat_rst: assert property (p_lat_rst) else $error("latch not cleared");

			property p_rmw_in;
				sfr_bit_wr_i && g_port[k].hit_lat |=> $stable(pin_oe_n_o[k*GPB_W +: GPB_W]);
			endproperty
			a_rmw_in: assert property (p_rmw_in) else $error("bit write moved drive enable");

			property p_bit_pub;
				sfr_bit_wr_i && g_port[k].hit_pub |=> pif[k].pub ==
					gpb_merge_bit($past(pif[k].pub), $past(sfr_bit_sel_i), $past(sfr_bit_val_i));
			endproperty
			a_bit_pub: assert property (p_bit_pub) else $error("bit pull-up write wrong");

			property p_byte_pub;
				sfr_wr_i && !sfr_bit_wr_i && g_port[k].hit_pub |=> pif[k].pub == $past(sfr_wdata_i);
			endproperty
			a_byte_pub: assert property (p_byte_pub) else $error("pull-up byte write lost");

			property p_pub_none;
				GPB_HAS_PU[k] || pif[k].pub == GPB_PUB_RST;
			endproperty
			a_pub_none: assert property (p_pub_none) else $error("pull-up select without pull-ups");

			property p_oe_hold;
				!pif[k].wr_dir |=> $stable(pin_oe_n_o[k*GPB_W +: GPB_W]);
			endproperty
			a_oe_hold: assert property (p_oe_hold) else $error("drive enable changed unwritten");

			property p_rd_keep;
				sfr_rd_i && !wr_any && g_port[k].hit_lat |=> $stable(pif[k].lat);
			endproperty
			a_rd_keep: assert property (p_rd_keep) else $error("read changed latch");

			property p_level;
				!$past(srst_i) && !$past(srst_i, 2)
					|-> pif[k].level == $past(pin_i[k*GPB_W +: GPB_W], 2);
			endproperty
			a_level: assert property (p_level) else $error("pin level not followed");
		end
	endgenerate

	property p_key_int;
		{ext_interrupt_input_1_o, ext_interrupt_input_0_o, key_return_inputs_low_o}
			== pif[GPB_KEY_PORT].level
			&& {key_return_input_7_o, key_return_input_6_o} == pif[GPB_KEY_PORT].level[7:6];
	endproperty
	a_key_int: assert property (p_key_int) else $error("key or interrupt input wrong");

	property p_rd_hold;
		!sfr_rd_i |=> $stable(sfr_rdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data changed unread");

	c_byte_wr: cover property (sfr_wr_i && g_port[0].hit_lat);
	c_bit_wr: cover property (sfr_bit_wr_i && g_port[2].hit_lat ##1 sfr_rd_i);
	c_rd_in: cover property (sfr_rd_i && g_port[1].hit_lat && pif[1].dir != '0);
	c_pullup: cover property (pullup_en_o != '0);
	c_rmw_out: cover property (sfr_bit_wr_i && g_port[0].hit_lat && pif[0].dir == '0);
endmodule

/* File: verif/gpb_pad_model.sv */
// Pad model for the 24 port pins: block drive, bench drive, pull-ups.
// Assumes active-low drive enables; an undriven floating pin toggles.
`timescale 1ns/1ns
module gpb_pad_model (
	input wire logic clk_sys_i,
	input wire logic [23:0] pin_o_i,
	input wire logic [23:0] pin_oe_n_i,
	input wire logic [15:0] pullup_en_i,
	input wire logic [23:0] ext_val_i,
	input wire logic [23:0] ext_en_i,
	output logic [23:0] pad_o
);
	logic [23:0] pu;
	logic [23:0] last = 24'h000000;
	assign pu = {pullup_en_i[15:8], 8'h00, pullup_en_i[7:0]};
	always_ff @(posedge clk_sys_i) begin
		last <= pad_o;
	end
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			if (!pin_oe_n_i[i]) begin
				pad_o[i] = pin_o_i[i];
			end else if (ext_en_i[i]) begin
				pad_o[i] = ext_val_i[i];
			end else if (pu[i]) begin
				pad_o[i] = 1'b1;
			end else begin
				pad_o[i] = ~last[i];
			end
		end
	end
endmodule

/* File: verif/three_port_gpio_block_tb.sv */
// Self-checking bench for the three-port GPIO block.
// Assumes the pad model on the pins; inputs change on falling edges.
`timescale 1ns/1ns
module three_port_gpio_block_tb import gpb_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic wr = 1'b0;
	logic bwr = 1'b0;
	logic bval = 1'b0;
	logic rd = 1'b0;
	logic tmr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [2:0] bsel = 3'h0;
	logic [7:0] rdata;
	logic [23:0] pin_i, pin_o, oe_n;
	logic [23:0] ext_val = 24'h000000;
	logic [23:0] ext_en = 24'hffffff;
	logic [15:0] pu_en;
	logic [5:0] krl;
	logic cpt, kr6, kr7, int0, int1;
	logic [7:0] d, l, e, p, v;
	logic [2:0] s;
	int err_total = 0;
	int tests_run = 0;
	int j;
	gpb_top dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
		.sfr_wdata_i(wdata), .sfr_bit_wr_i(bwr), .sfr_bit_sel_i(bsel), .sfr_bit_val_i(bval),
		.sfr_rd_i(rd), .sfr_rdata_o(rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n),
		.pullup_en_o(pu_en), .timer_output_pin_i(tmr), .capture_trigger_input_o(cpt),
		.key_return_inputs_low_o(krl), .key_return_input_6_o(kr6),
		.key_return_input_7_o(kr7), .ext_interrupt_input_0_o(int0),
		.ext_interrupt_input_1_o(int1));
	gpb_pad_model pads (.clk_sys_i(clk_sys_i), .pin_o_i(pin_o), .pin_oe_n_i(oe_n),
		.pullup_en_i(pu_en), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_o(pin_i));
	// ********************************
	// Tasks
	// ********************************
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results;
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wr8(input logic [15:0] a, input logic [7:0] dat);
		@(negedge clk_sys_i);
		addr = a;
		wdata = dat;
		wr = 1'b1;
		@(negedge clk_sys_i);
		wr = 1'b0;
	endtask
	task automatic wbit(input logic [15:0] a, input logic [2:0] sel, input logic val);
		@(negedge clk_sys_i);
		addr = a;
		bsel = sel;
		bval = val;
		bwr = 1'b1;
		@(negedge clk_sys_i);
		bwr = 1'b0;
	endtask
	task automatic rd8(input logic [15:0] a, output logic [7:0] q);
		@(negedge clk_sys_i);
		addr = a;
		rd = 1'b1;
		@(negedge clk_sys_i);
		rd = 1'b0;
		q = rdata;
	endtask
	task automatic settle;
		repeat (4) @(negedge clk_sys_i);
	endtask
	task automatic reset_and_check;
		logic [7:0] q;
		@(negedge clk_sys_i);
		srst_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		srst_i = 1'b0;
		chk("pullup_en", 8'h00, pu_en[7:0] | pu_en[15:8]);
		for (int i = 0; i < 3; i++) begin
			chk("oe_n", 8'hff, oe_n[i*8+:8]);
			chk("pin_o", GPB_LAT_RST, pin_o[i*8+:8]);
			rd8(GPB_DIR_ADDR[i], q);
			chk("direction", 8'hff, q);
			rd8(GPB_PUB_ADDR[i], q);
			chk("pullup_select", 8'h00, q);
		end
	endtask
	// ********************************
	// Scenarios
	// ********************************
	initial begin
		void'($urandom(47339));
		reset_and_check();
		for (int k = 0; k < 24; k++) begin
			j = k % 3;
			{d, l, e, p} = $urandom;
			ext_val[j*8+:8] = e;
			wr8(GPB_DIR_ADDR[j], d);
			wr8(GPB_LAT_ADDR[j], l);
			wr8(GPB_PUB_ADDR[j], p);
			settle();
			rd8(GPB_LAT_ADDR[j], v);
			chk("port read", (l & ~d) | (e & d), v);
			chk("oe_n", d, oe_n[j*8+:8]);
			chk("pin_o", l, pin_o[j*8+:8]);
			chk("pad", (l & ~d) | (e & d), pin_i[j*8+:8]);
			if (j != 1) begin
				chk("pullup_en", p & d, pu_en[(j/2)*8+:8]);
			end
			rd8(GPB_PUB_ADDR[j], v);
			chk("pullup_select", GPB_HAS_PU[j] ? p : 8'h00, v);
			s = 3'($urandom);
			p[s] = ~p[s];
			wbit(GPB_PUB_ADDR[j], s, p[s]);
			rd8(GPB_PUB_ADDR[j], v);
			chk("pullup_select bit", GPB_HAS_PU[j] ? p : 8'h00, v);
			s = 3'($urandom);
			d[s] = $urandom;
			wbit(GPB_DIR_ADDR[j], s, d[s]);
			rd8(GPB_DIR_ADDR[j], v);
			chk("direction bit", d, v);
			settle();
			l = (l & ~d) | (e & d);
			s = 3'($urandom);
			l[s] = $urandom;
			wbit(GPB_LAT_ADDR[j], s, l[s]);
			wr8(GPB_DIR_ADDR[j], 8'h00);
			settle();
			rd8(GPB_LAT_ADDR[j], v);
			chk("latch after bit", l, v);
			chk("pin after bit", l, pin_i[j*8+:8]);
			s = 3'($urandom);
			l[s] = ~l[s];
			wbit(GPB_LAT_ADDR[j], s, l[s]);
			rd8(GPB_LAT_ADDR[j], v);
			chk("latch output bit", l, v);
		end
		ext_en[7:0] = 8'h00;
		wr8(GPB_DIR_ADDR[0], 8'hff);
		wr8(GPB_PUB_ADDR[0], 8'hff);
		settle();
		rd8(GPB_LAT_ADDR[0], v);
		chk("pulled port", 8'hff, v);
		ext_en = 24'hffffff;
		e = $urandom;
		ext_val[23:16] = e;
		ext_val[12] = ~e[0];
		wr8(GPB_DIR_ADDR[2], 8'hff);
		wr8(GPB_DIR_ADDR[1], 8'hf7);
		settle();
		chk("key return", e, {kr7, kr6, krl});
		chk("interrupts", {6'h00, e[7:6]}, {6'h00, int1, int0});
		chk("capture", {7'h00, ~e[0]}, {7'h00, cpt});
		wr8(GPB_LAT_ADDR[1], 8'h00);
		wr8(GPB_LAT_ADDR[2], ~e);
		wr8(GPB_DIR_ADDR[2], 8'h00);
		tmr = 1'b1;
		settle();
		chk("interrupts driven", {6'h00, ~e[7:6]}, {6'h00, int1, int0});
		chk("timer pin", 8'h01, {7'h00, pin_i[11]});
		tmr = 1'b0;
		settle();
		chk("timer pin idle", 8'h00, {7'h00, pin_i[11]});
		reset_and_check();
		results();
	end
	initial begin
		#3000000;
		err_total++;
		results();
	end
endmodule
